// [sfs_pkg.sv]
// sfs_pkg: opcodes, timing counts, states and carrier types of the
// serial flash command sequencer.
// assumes a 100 MHz system clock; the array itself lives outside the block.
package sfs_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // array geometry: three top address bits are dropped on entry
    localparam int ADDR_W     = 21;
    localparam int PAGE_LSB   = 8;
    localparam int SECTOR_LSB = 16;
    localparam int SECTOR_W   = 5;
    localparam int PAGE_BYTES = 256;

    // instruction codes
    localparam logic [7:0] OPC_FAST_READ     = 8'h0B;
    localparam logic [7:0] OPC_PAGE_WRITE    = 8'h02;
    localparam logic [7:0] OPC_SECTOR_CLEAR  = 8'hD8;
    localparam logic [7:0] OPC_ARRAY_CLEAR   = 8'hC7;
    localparam logic [7:0] OPC_SLEEP_ENTER   = 8'hB9;
    localparam logic [7:0] OPC_WAKE_AND_SIG  = 8'hAB;
    localparam logic [7:0] OPC_WRITE_UNLOCK  = 8'h06;

    // legacy signature; value is arbitrary
    localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5A;

    // self-timed durations in their own units, then in clock cycles
    localparam int PAGE_WRITE_TIME_US   = 1000;
    localparam int SECTOR_CLEAR_TIME_MS = 500;
    localparam int ARRAY_CLEAR_TIME_MS  = 10000;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int WAKE_DELAY_NS        = 30000;

    localparam int PAGE_WRITE_CYC   = PAGE_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int SECTOR_CLEAR_CYC = SECTOR_CLEAR_TIME_MS * 100000;
    localparam int ARRAY_CLEAR_CYC  = ARRAY_CLEAR_TIME_MS * 100000;
    localparam int SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYC         = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // serial front end states, gray along opcode/address/dummy/output
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_OPC     = 4'h1,
        ST_ADDR    = 4'h3,
        ST_DUMMY   = 4'h2,
        ST_RD_OUT  = 4'h6,
        ST_SIG_OUT = 4'h7,
        ST_PROG_IN = 4'h5,
        ST_HOLD    = 4'h4,
        ST_IGNORE  = 4'hC
    } sfs_state_e;

    typedef enum logic [2:0] {
        CMD_NONE         = 3'h0,
        CMD_FAST_READ    = 3'h1,
        CMD_PAGE_WRITE   = 3'h2,
        CMD_SECTOR_CLEAR = 3'h3,
        CMD_ARRAY_CLEAR  = 3'h4,
        CMD_SLEEP_ENTER  = 3'h5,
        CMD_WAKE_AND_SIG = 3'h6,
        CMD_WRITE_UNLOCK = 3'h7
    } sfs_cmd_e;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } sfs_mem_wr_s;

    typedef struct packed {
        logic                sector;
        logic                all;
        logic [SECTOR_W-1:0] idx;
    } sfs_erase_s;

endpackage

// [sfs_pin_sync.sv]
// sfs_pin_sync: two-stage synchronisers for the serial pins, plus a
// delayed copy of the synchronised level for edge detection.
// assumes pins are asynchronous to CLOCK and change far slower than it.
`timescale 1ns/100ps
module sfs_pin_sync #(
    parameter int N = 3
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] rst_val,
    // pins and synchronised levels
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] sync_out,
    output logic      [N-1:0] prev_out
);
    logic [N-1:0] meta_r;

    // the first stage feeds the second and nothing else
    for (genvar i = 0; i < N; i++) begin : g_bit
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                meta_r[i]   <= 1'b1;
                sync_out[i] <= 1'b1;
                prev_out[i] <= 1'b1;
            end else begin
                meta_r[i]   <= pin_in[i];
                sync_out[i] <= meta_r[i];
                prev_out[i] <= sync_out[i];
            end
        end
    end

    // rst_val unused beyond documenting idle level: every stage of every pin resets high
    logic unused_ok;
    assign unused_ok = &rst_val;
endmodule // sfs_pin_sync

// [sfs_timer.sv]
// sfs_timer: loadable down counter for self-timed cycles and delays.
// assumes load is a one-cycle pulse; a load while running restarts it.
`timescale 1ns/100ps
module sfs_timer #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    // status
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_r;

    assign busy = (cnt_r != '0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                cnt_r <= count;
            end else if (busy) begin
                cnt_r <= cnt_r - 1'b1;
                done  <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
            end
        end
    end
endmodule // sfs_timer

// [sfs_sequencer.sv]
// sfs_sequencer: instruction handling of a serial flash for high-speed
// read, page write, sector and array clear, sleep entry and wake.
// assumes mode-0 style clocking far below CLOCK, and an external array
// that answers MEM_RD_ADDR on MEM_RD_DATA within two clocks.
//
// How it works
// - fast read is opcode, three address bytes, one dummy; bits taken on rising clock
// - read data leaves on falling edges from the given address after the dummy
// - read address steps per byte and wraps to zero at the top
// - three top address bits are dropped for every command
// - select rising ends a read at any point and releases the output
// - fast read during a busy cycle is rejected without side effects
// - page write and both clears need the unlock latch set beforehand
// - page data past the page end wraps to the page start
// - over 256 bytes keeps the last 256; fewer touches only addressed bytes
// - page write runs only if select rises on a byte boundary after data
// - valid select rise starts the timed cycle; busy flag high until done
// - unlock latch clears before each timed cycle completes
// - page write into a protected page is not executed
// - sector clear is opcode plus address; whole sector is set to ones
// - sector clear runs only if select rises right after the address
// - sector clear into a protected area is not executed
// - array clear is opcode only and runs only with no protection bits set
// - sleep entry is opcode only, select rising after bit eight, then delay
// - while asleep only the wake command is decoded
// - sleep entry during a busy cycle is rejected
// - wake takes three dummy bytes then repeats the signature on falling edges
// - wake during a busy cycle is not decoded
// - select rising after wake returns to standby, delayed only if asleep or entering sleep
`timescale 1ns/100ps
module sfs_sequencer
    import sfs_pkg::*;
#(
    parameter int          PAGE_WRITE_CYCLES   = sfs_pkg::PAGE_WRITE_CYC,
    parameter int          SECTOR_CLEAR_CYCLES = sfs_pkg::SECTOR_CLEAR_CYC,
    parameter int          ARRAY_CLEAR_CYCLES  = sfs_pkg::ARRAY_CLEAR_CYC,
    parameter int          SLEEP_ENTRY_CYCLES  = sfs_pkg::SLEEP_ENTRY_CYC,
    parameter int          WAKE_CYCLES         = sfs_pkg::WAKE_CYC,
    parameter logic [7:0]  SIGNATURE           = sfs_pkg::SIGNATURE_DEFAULT
) (
    // clock and reset
    input  wire logic                      CLOCK,
    input  wire logic                      RESET,
    // serial pins
    input  wire logic                      SEL_N,
    input  wire logic                      SCLK,
    input  wire logic                      SDI,
    output logic                           SDO,
    output logic                           SDO_OE,
    // status from and to the status register logic
    input  wire logic [2:0]                PROTECT_AREA_BITS,
    input  wire logic                      STATUS_WRITE_BUSY,
    output logic                           CYCLE_ACTIVE_FLAG,
    output logic                           WRITE_UNLOCK_LATCH,
    output logic                           SLEEP_ACTIVE,
    // array port
    output logic [sfs_pkg::ADDR_W-1:0]     MEM_RD_ADDR,
    input  wire logic [7:0]                MEM_RD_DATA,
    output sfs_pkg::sfs_mem_wr_s           MEM_WR,
    output sfs_pkg::sfs_erase_s            MEM_ERASE
);
    import sfs_pkg::*;

    // synchronised pins and edges
    logic [2:0]        pin_s;
    logic [2:0]        pin_p;
    logic              sel_n_s;
    logic              sck_s;
    logic              sdi_s;
    logic              sck_rise;
    logic              sck_fall;
    logic              sel_rise;
    logic              sel_fall;

    // front end state
    sfs_state_e        state_r;
    sfs_cmd_e          cmd_r;
    logic [2:0]        bit_cnt_r;
    logic [1:0]        byte_cnt_r;
    logic [6:0]        in_sr_r;
    logic [ADDR_W-1:0] addr_r;
    logic              got_data_r;
    logic [2:0]        out_cnt_r;
    logic [6:0]        out_sr_r;

    // execution state
    logic              wip_r;
    logic              wel_r;
    logic              asleep_r;
    logic              sleep_pend_r;
    logic              wake_pend_r;
    logic              walk_r;
    logic [7:0]        walk_idx_r;
    logic [ADDR_W-PAGE_LSB-1:0] prog_page_r;
    logic [7:0]        page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] valid_r;

    sfs_pin_sync #(.N(3)) u_sync (
        .clk      (CLOCK),
        .rst      (RESET),
        .rst_val  (3'h7),
        .pin_in   ({SEL_N, SCLK, SDI}),
        .sync_out (pin_s),
        .prev_out (pin_p)
    );

    assign sel_n_s  = pin_s[2];
    assign sck_s    = pin_s[1];
    assign sdi_s    = pin_s[0];
    assign sck_rise = ~sel_n_s & sck_s & ~pin_p[1];
    assign sck_fall = ~sel_n_s & ~sck_s & pin_p[1];
    assign sel_rise = sel_n_s & ~pin_p[2];
    assign sel_fall = ~sel_n_s & pin_p[2];

    // incoming byte, msb first
    logic [7:0] in_byte;
    logic       byte_done;
    assign in_byte   = {in_sr_r, sdi_s};
    assign byte_done = sck_rise & (bit_cnt_r == 3'h7);

    logic busy;
    logic sleepy;
    assign busy   = wip_r | STATUS_WRITE_BUSY;
    assign sleepy = asleep_r | sleep_pend_r;

    // opcode decode
    sfs_cmd_e dec_cmd;
    assign dec_cmd = (in_byte == OPC_FAST_READ)    ? CMD_FAST_READ    :
                     (in_byte == OPC_PAGE_WRITE)   ? CMD_PAGE_WRITE   :
                     (in_byte == OPC_SECTOR_CLEAR) ? CMD_SECTOR_CLEAR :
                     (in_byte == OPC_ARRAY_CLEAR)  ? CMD_ARRAY_CLEAR  :
                     (in_byte == OPC_SLEEP_ENTER)  ? CMD_SLEEP_ENTER  :
                     (in_byte == OPC_WAKE_AND_SIG) ? CMD_WAKE_AND_SIG :
                     (in_byte == OPC_WRITE_UNLOCK) ? CMD_WRITE_UNLOCK : CMD_NONE;

    // busy rejects everything here; asleep leaves only wake
    logic dec_ok;
    assign dec_ok = (dec_cmd != CMD_NONE) & ~busy
                  & (~sleepy | (dec_cmd == CMD_WAKE_AND_SIG));

    sfs_state_e dec_next;
    assign dec_next = ~dec_ok                            ? ST_IGNORE :
                      (dec_cmd == CMD_FAST_READ)   ||
                      (dec_cmd == CMD_PAGE_WRITE)  ||
                      (dec_cmd == CMD_SECTOR_CLEAR)||
                      (dec_cmd == CMD_WAKE_AND_SIG)      ? ST_ADDR   : ST_HOLD;

    sfs_state_e addr_next;
    assign addr_next = (cmd_r == CMD_FAST_READ)  ? ST_DUMMY   :
                       (cmd_r == CMD_PAGE_WRITE) ? ST_PROG_IN :
                       (cmd_r == CMD_WAKE_AND_SIG) ? ST_SIG_OUT : ST_HOLD;

    logic shifting;
    assign shifting = (state_r == ST_OPC) | (state_r == ST_ADDR) | (state_r == ST_DUMMY)
                    | (state_r == ST_PROG_IN);

    // output byte source
    logic       out_load;
    logic [7:0] out_byte;
    assign out_load = sck_fall & (out_cnt_r == 3'h0);
    assign out_byte = (state_r == ST_SIG_OUT) ? SIGNATURE : MEM_RD_DATA;
    assign MEM_RD_ADDR = addr_r;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            state_r    <= ST_IDLE;
            cmd_r      <= CMD_NONE;
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 2'h0;
            in_sr_r    <= 7'h00;
            addr_r     <= '0;
            got_data_r <= 1'b0;
        end else if (sel_fall) begin
            state_r    <= ST_OPC;
            cmd_r      <= CMD_NONE;
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 2'h0;
            got_data_r <= 1'b0;
        end else if (sel_rise) begin
            state_r <= ST_IDLE;
        end else if (sck_rise && state_r == ST_HOLD) begin
            state_r <= ST_IGNORE;
        end else if (sck_rise && shifting) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            in_sr_r   <= in_byte[6:0];
            if (byte_done) begin
                unique case (state_r)
                    ST_OPC: begin
                        cmd_r   <= dec_cmd;
                        state_r <= dec_next;
                    end
                    ST_ADDR: begin
                        addr_r     <= {addr_r[ADDR_W-9:0], in_byte};
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                        if (byte_cnt_r == 2'h2) begin
                            state_r <= addr_next;
                        end
                    end
                    ST_DUMMY: state_r <= ST_RD_OUT;
                    ST_PROG_IN: begin
                        got_data_r  <= 1'b1;
                        addr_r[7:0] <= addr_r[7:0] + 8'h01;
                    end
                    default: state_r <= state_r;
                endcase
            end
        end else if (out_load && state_r == ST_RD_OUT) begin
            addr_r <= addr_r + 1'b1;
        end
    end

    // serial output changes on falling edges
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            SDO       <= 1'b0;
            SDO_OE    <= 1'b0;
            out_cnt_r <= 3'h0;
            out_sr_r  <= 7'h00;
        end else if (sel_fall || sel_rise) begin
            SDO_OE    <= 1'b0;
            out_cnt_r <= 3'h0;
        end else if (sck_fall && (state_r == ST_RD_OUT || state_r == ST_SIG_OUT)) begin
            SDO_OE    <= 1'b1;
            out_cnt_r <= out_cnt_r + 3'h1;
            if (out_load) begin
                SDO      <= out_byte[7];
                out_sr_r <= out_byte[6:0];
            end else begin
                SDO      <= out_sr_r[6];
                out_sr_r <= {out_sr_r[5:0], 1'b0};
            end
        end
    end

    // protection: bp selects the top 2^(bp-1) sectors, 6 and up covers all
    logic [SECTOR_W-1:0] prot_mask;
    logic                page_prot;
    logic                sect_prot;
    assign prot_mask = 5'h1F << (PROTECT_AREA_BITS - 3'h1);
    assign page_prot = (PROTECT_AREA_BITS != 3'h0)
                     & ((addr_r[ADDR_W-1:SECTOR_LSB] & prot_mask) == prot_mask);
    assign sect_prot = page_prot;

    // commit on select rising
    logic start_prog;
    logic start_sect;
    logic start_all;
    logic start_write;
    logic start_sleep;
    logic do_unlock;
    logic do_wake;
    logic hold_cmd;
    assign hold_cmd    = sel_rise & (state_r == ST_HOLD);
    assign start_prog  = sel_rise & (state_r == ST_PROG_IN) & (bit_cnt_r == 3'h0)
                       & got_data_r & wel_r & ~page_prot;
    assign start_sect  = hold_cmd & (cmd_r == CMD_SECTOR_CLEAR) & wel_r
                       & ~sect_prot;
    assign start_all   = hold_cmd & (cmd_r == CMD_ARRAY_CLEAR) & wel_r
                       & (PROTECT_AREA_BITS == 3'h0);
    assign start_write = start_prog | start_sect | start_all;
    assign start_sleep = hold_cmd & (cmd_r == CMD_SLEEP_ENTER);
    assign do_unlock   = hold_cmd & (cmd_r == CMD_WRITE_UNLOCK);
    assign do_wake     = sel_rise & (cmd_r == CMD_WAKE_AND_SIG)
                       & (state_r != ST_IGNORE) & (state_r != ST_IDLE);

    logic [31:0] wtime;
    logic        wbusy;
    logic        wdone;
    logic        pdone;
    assign wtime = start_prog ? 32'(PAGE_WRITE_CYCLES) :
                   start_sect ? 32'(SECTOR_CLEAR_CYCLES) : 32'(ARRAY_CLEAR_CYCLES);

    sfs_timer #(.W(32)) u_write_timer (
        .clk   (CLOCK),
        .rst   (RESET),
        .load  (start_write),
        .count (wtime),
        .busy  (wbusy),
        .done  (wdone)
    );

    sfs_timer #(.W(32)) u_power_timer (
        .clk   (CLOCK),
        .rst   (RESET),
        .load  (start_sleep | (do_wake & sleepy)),
        .count (start_sleep ? 32'(SLEEP_ENTRY_CYCLES) : 32'(WAKE_CYCLES)),
        .busy  (),
        .done  (pdone)
    );

    // page buffer holds only data; valid bits decide what gets written
    logic prog_wr;
    logic clr_valid;
    assign prog_wr   = byte_done & (state_r == ST_PROG_IN);
    assign clr_valid = byte_done & (state_r == ST_OPC) & (dec_cmd == CMD_PAGE_WRITE) & dec_ok;

    always_ff @(posedge CLOCK) begin
        if (prog_wr) begin
            page_buf[addr_r[7:0]] <= in_byte;
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            wip_r        <= 1'b0;
            wel_r        <= 1'b0;
            asleep_r     <= 1'b0;
            sleep_pend_r <= 1'b0;
            wake_pend_r  <= 1'b0;
            walk_r       <= 1'b0;
            walk_idx_r   <= 8'h00;
            prog_page_r  <= '0;
            valid_r      <= '0;
            MEM_WR       <= '0;
            MEM_ERASE    <= '0;
        end else begin
            MEM_WR.en        <= 1'b0;
            MEM_ERASE.sector <= 1'b0;
            MEM_ERASE.all    <= 1'b0;
            if (start_write) begin
                wip_r <= 1'b1;
                wel_r <= 1'b0;
            end else if (wdone) begin
                wip_r <= 1'b0;
            end else if (do_unlock) begin
                wel_r <= 1'b1;
            end
            if (clr_valid) begin
                valid_r <= '0;
            end else if (prog_wr) begin
                valid_r[addr_r[7:0]] <= 1'b1;
            end else if (walk_r) begin
                valid_r[walk_idx_r] <= 1'b0;
            end
            if (start_prog) begin
                walk_r      <= 1'b1;
                walk_idx_r  <= 8'h00;
                prog_page_r <= addr_r[ADDR_W-1:PAGE_LSB];
            end else if (walk_r) begin
                MEM_WR.en   <= valid_r[walk_idx_r];
                MEM_WR.addr <= {prog_page_r, walk_idx_r};
                MEM_WR.data <= page_buf[walk_idx_r];
                walk_idx_r  <= walk_idx_r + 8'h01;
                walk_r      <= (walk_idx_r != 8'hFF);
            end
            if (start_sect || start_all) begin
                MEM_ERASE.sector <= start_sect;
                MEM_ERASE.all    <= start_all;
                MEM_ERASE.idx    <= addr_r[ADDR_W-1:SECTOR_LSB];
            end
            if (start_sleep) begin
                sleep_pend_r <= 1'b1;
            end else if (do_wake) begin
                sleep_pend_r <= 1'b0;
                wake_pend_r  <= sleepy;
                asleep_r     <= sleepy;
            end else if (pdone && wake_pend_r) begin
                asleep_r    <= 1'b0;
                wake_pend_r <= 1'b0;
            end else if (pdone && sleep_pend_r) begin
                asleep_r     <= 1'b1;
                sleep_pend_r <= 1'b0;
            end
        end
    end

    assign CYCLE_ACTIVE_FLAG  = wip_r;
    assign WRITE_UNLOCK_LATCH = wel_r;
    assign SLEEP_ACTIVE       = asleep_r;

    logic unused_ok;
    assign unused_ok = wbusy;
endmodule // sfs_sequencer

// [sfs_sequencer_sva.sv]
// sfs_sequencer_sva: port-level checks of the command sequencer.
// assumes the top ports of sfs_sequencer; attached by the bind below.
`timescale 1ns/100ps
module sfs_sequencer_sva
    import sfs_pkg::*;
(
    // clock and reset
    input wire logic                 CLOCK,
    input wire logic                 RESET,
    // pins and status
    input wire logic                 SEL_N,
    input wire logic                 SDO_OE,
    input wire logic [2:0]           PROTECT_AREA_BITS,
    input wire logic                 CYCLE_ACTIVE_FLAG,
    input wire logic                 WRITE_UNLOCK_LATCH,
    input wire logic                 SLEEP_ACTIVE,
    // array strobes
    input wire sfs_pkg::sfs_mem_wr_s MEM_WR,
    input wire sfs_pkg::sfs_erase_s  MEM_ERASE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    a_latch_drops: assert property ($rose(CYCLE_ACTIVE_FLAG) |-> ##[0:2] !WRITE_UNLOCK_LATCH)
        else $error("latch kept");
    a_cycle_needs_unlock: assert property ($rose(CYCLE_ACTIVE_FLAG) |-> SEL_N && $past(WRITE_UNLOCK_LATCH))
        else $error("cycle without latch");
    a_write_in_cycle: assert property (MEM_WR.en |->
        CYCLE_ACTIVE_FLAG && !WRITE_UNLOCK_LATCH)
        else $error("write outside cycle");
    a_erase_in_cycle: assert property (MEM_ERASE.sector || MEM_ERASE.all |-> CYCLE_ACTIVE_FLAG)
        else $error("erase outside cycle");
    a_all_unprotected: assert property (MEM_ERASE.all |-> PROTECT_AREA_BITS == 3'h0)
        else $error("array clear while protected");
    a_out_released: assert property (SEL_N [*5] |-> !SDO_OE)
        else $error("output held");
    a_out_selected: assert property ($rose(SDO_OE) |-> !SEL_N)
        else $error("output unselected");
    a_sleep_idle: assert property ($rose(SLEEP_ACTIVE) |-> !CYCLE_ACTIVE_FLAG && SEL_N)
        else $error("sleep in cycle");
    a_asleep_quiet: assert property (SLEEP_ACTIVE |-> !MEM_WR.en && !MEM_ERASE.all)
        else $error("work while asleep");
    c_write: cover property (MEM_WR.en);
    c_sector: cover property (MEM_ERASE.sector);
    c_sleep: cover property ($fell(SLEEP_ACTIVE));
endmodule // sfs_sequencer_sva

bind sfs_sequencer sfs_sequencer_sva u_sva (.CLOCK(CLOCK), .RESET(RESET), .SEL_N(SEL_N),
    .SDO_OE(SDO_OE), .PROTECT_AREA_BITS(PROTECT_AREA_BITS), .MEM_WR(MEM_WR),
    .CYCLE_ACTIVE_FLAG(CYCLE_ACTIVE_FLAG), .WRITE_UNLOCK_LATCH(WRITE_UNLOCK_LATCH),
    .SLEEP_ACTIVE(SLEEP_ACTIVE), .MEM_ERASE(MEM_ERASE));

// [sfs_spi_host.sv]
// sfs_spi_host: mode-0 serial host that frames commands and collects replies.
// assumes calls from the bench; pins move on CLOCK falling edges only.
`timescale 1ns/100ps
module sfs_spi_host (
    // clock
    input wire logic clk,
    // serial pins
    output logic     sel_n,
    output logic     sclk,
    output logic     sdi,
    input wire logic sdo
);
    logic [7:0] rd[$];
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    task automatic half;
        repeat (8) @(negedge clk);
    endtask
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            sdi = b[i];
            half();
            r[i] = sdo;
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
    endtask
    // select only rises on a byte boundary; sdi flips after release
    task automatic frame(input logic [7:0] q[$], input int nrd);
        logic [7:0] r;
        rd.delete();
        sel_n = 1'b0;
        half();
        foreach (q[k]) xfer(q[k], r);
        for (int k = 0; k < nrd; k++) begin
            xfer(8'hFF, r);
            rd.push_back(r);
        end
        half();
        sel_n = 1'b1;
        sdi = ~sdi;
        half();
        half();
    endtask
endmodule // sfs_spi_host

// [test_sfs_sequencer.sv]
// test_sfs_sequencer: self-checking bench of the command sequencer.
// assumes sfs_spi_host as the far side and a formula array on the read port.
`timescale 1ns/100ps
module test_sfs_sequencer;
    import sfs_pkg::*;
    logic        CLOCK = 0, RESET = 1, SEL_N, SCLK, SDI, SDO, SDO_OE, oe_seen;
    logic        CYCLE_ACTIVE_FLAG, WRITE_UNLOCK_LATCH, SLEEP_ACTIVE;
    logic [2:0]  PROTECT_AREA_BITS = 0;
    logic        STATUS_WRITE_BUSY = 0;
    logic [20:0] MEM_RD_ADDR;
    logic [23:0] a;
    logic [7:0]  s = 8'h5B;
    logic [28:0] wq[$];
    sfs_mem_wr_s MEM_WR;
    sfs_erase_s  MEM_ERASE, eq[$];
    int          miscompares = 0, checked = 0;
    always #5 CLOCK = ~CLOCK;
    function automatic logic [7:0] mem(input logic [20:0] x);
        return x[7:0] ^ x[20:13];
    endfunction
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    sfs_spi_host host (.clk(CLOCK), .sel_n(SEL_N), .sclk(SCLK), .sdi(SDI), .sdo(SDO));
    // short timed cycles keep the run small; the page walk still fits
    sfs_sequencer #(.PAGE_WRITE_CYCLES(400), .SECTOR_CLEAR_CYCLES(400), .ARRAY_CLEAR_CYCLES(500),
        .SLEEP_ENTRY_CYCLES(20), .WAKE_CYCLES(30)) dut (.CLOCK, .RESET,
        .SEL_N, .SCLK, .SDI, .SDO, .SDO_OE, .PROTECT_AREA_BITS, .STATUS_WRITE_BUSY,
        .CYCLE_ACTIVE_FLAG, .WRITE_UNLOCK_LATCH, .SLEEP_ACTIVE, .MEM_RD_ADDR,
        .MEM_RD_DATA(mem(MEM_RD_ADDR)), .MEM_WR, .MEM_ERASE);
    always @(posedge CLOCK) begin
        if (MEM_WR.en === 1'b1) wq.push_back(MEM_WR[28:0]);
        if (MEM_ERASE.sector === 1'b1 || MEM_ERASE.all === 1'b1) eq.push_back(MEM_ERASE);
        if (SDO_OE === 1'b1) oe_seen <= 1'b1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic idle_wait;
        for (int k = 0; k < 900 && CYCLE_ACTIVE_FLAG !== 1'b0; k++) @(negedge CLOCK);
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #300us;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge CLOCK);
        @(negedge CLOCK);
        RESET = 0;
        repeat (4) @(negedge CLOCK);
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 24'hFFFFFF : {s, ~s, s};
            s = lfsr(s);
            host.frame({OPC_FAST_READ, a[23:16], a[15:8], a[7:0], 8'h00}, 2);
            chk(host.rd[0], mem(a[20:0]));
            chk(host.rd[1], mem(a[20:0] + 21'h1));
        end
        chk(SDO_OE, 0);
        host.frame({OPC_PAGE_WRITE, 8'h00, 8'h00, 8'h00, 8'h55}, 0);
        chk(CYCLE_ACTIVE_FLAG, 0);
        host.frame({OPC_WRITE_UNLOCK}, 0);
        host.frame({OPC_PAGE_WRITE, 8'hE1, 8'h23, 8'hFE, 8'h11, 8'h22, 8'h33}, 0);
        chk(CYCLE_ACTIVE_FLAG, 1);
        chk(WRITE_UNLOCK_LATCH, 0);
        oe_seen = 0;
        host.frame({OPC_FAST_READ, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
        chk(oe_seen, 0);
        idle_wait();
        chk(wq.size(), 3);
        // the walk visits the page from its start, so the wrapped byte comes out first
        for (int k = 0; k < 3; k++)
            chk(wq[k], {13'h0123, 8'hFE + 8'((k + 2) % 3), 8'h11 * 8'((k + 2) % 3 + 1)});
        PROTECT_AREA_BITS = 3'h1;
        host.frame({OPC_WRITE_UNLOCK}, 0);
        host.frame({OPC_SECTOR_CLEAR, 8'hFF, 8'h00, 8'h00}, 0);
        chk(CYCLE_ACTIVE_FLAG, 0);
        host.frame({OPC_WRITE_UNLOCK}, 0);
        host.frame({OPC_SECTOR_CLEAR, 8'hE3, 8'h45, 8'h67}, 0);
        idle_wait();
        chk(eq.size(), 1);
        chk(eq[0].idx, 3);
        // latch set, so only the protection can stop this clear
        host.frame({OPC_WRITE_UNLOCK}, 0);
        host.frame({OPC_ARRAY_CLEAR}, 0);
        chk(CYCLE_ACTIVE_FLAG, 0);
        chk(eq.size(), 1);
        PROTECT_AREA_BITS = 3'h0;
        host.frame({OPC_WRITE_UNLOCK}, 0);
        host.frame({OPC_ARRAY_CLEAR}, 0);
        idle_wait();
        chk(eq[eq.size() - 1].all, 1);
        // a status write in progress counts as busy for sleep and wake alike
        STATUS_WRITE_BUSY = 1'b1;
        oe_seen = 0;
        host.frame({OPC_SLEEP_ENTER}, 0);
        host.frame({OPC_WAKE_AND_SIG, 8'h00, 8'h00, 8'h00}, 1);
        STATUS_WRITE_BUSY = 1'b0;
        chk(SLEEP_ACTIVE, 0);
        chk(oe_seen, 0);
        host.frame({OPC_SLEEP_ENTER}, 0);
        repeat (30) @(negedge CLOCK);
        chk(SLEEP_ACTIVE, 1);
        host.frame({OPC_WRITE_UNLOCK}, 0);
        chk(WRITE_UNLOCK_LATCH, 0);
        host.frame({OPC_WAKE_AND_SIG, 8'h00, 8'h00, 8'h00}, 2);
        chk(host.rd[0], SIGNATURE_DEFAULT);
        chk(host.rd[1], SIGNATURE_DEFAULT);
        chk(SLEEP_ACTIVE, 1);
        repeat (40) @(negedge CLOCK);
        chk(SLEEP_ACTIVE, 0);
        tally_and_finish();
    end
endmodule // test_sfs_sequencer
